// File: pkg/cid_pkg.sv
// constants and types for the caller-id call detector
package cid_pkg;
    localparam int CID_CLK_HZ = 40_000_000;
    localparam int CID_BAUD_SLOW = 9600;
    localparam int CID_BAUD_FAST = 19200;
    localparam logic [15:0] CID_DIV_SLOW = 16'(CID_CLK_HZ / CID_BAUD_SLOW);
    localparam logic [15:0] CID_DIV_FAST = 16'(CID_CLK_HZ / CID_BAUD_FAST);
    localparam int CID_PAT_LEN = 28;
    localparam int CID_RING_MIN = 1;
    localparam int CID_RING_MAX = 20;
    localparam int CID_DELAY_MAX_S = 10;
    localparam logic [7:0] CID_CH_CR = 8'h0d;
    localparam logic [7:0] CID_CH_LF = 8'h0a;
    localparam logic [7:0] CID_CH_QUOTE = 8'h22;
    localparam logic [7:0] CID_CH_STAR = 8'h2a;
    localparam logic [7:0] CID_CH_PLUS = 8'h2b;
    localparam logic [7:0] CID_CH_MINUS = 8'h2d;
    localparam logic [7:0] CID_CH_OPEN = 8'h28;
    localparam logic [7:0] CID_CH_CLOSE = 8'h29;
    localparam logic [7:0] CID_CH_ZERO = 8'h30;
    localparam logic [7:0] CID_CH_NINE = 8'h39;
    localparam logic [7:0] CID_CH_R = 8'h52;
    localparam logic [7:0] CID_CH_C = 8'h43;
    // parity settings
    localparam logic [1:0] CID_PAR_NONE = 2'h0;
    localparam logic [1:0] CID_PAR_ODD = 2'h1;
    localparam logic [1:0] CID_PAR_EVEN = 2'h2;
    // receiver states
    typedef enum logic [3:0] {
        CID_RX_IDLE = 4'b0001,
        CID_RX_DATA = 4'b0010,
        CID_RX_PAR = 4'b0100,
        CID_RX_STOP = 4'b1000
    } cid_rx_t;
endpackage : cid_pkg

// File: src/cid_caller_match_block.sv
// caller-id call detector: modem serial receiver, line parser, pattern match, bit output
// Behaviour
// [RULE1] count ring lines; take caller number only once ring count reached
// [RULE2] ring count setting clamped to one through twenty
// [RULE3] plain pattern matches only same length and identical digits
// [RULE4] output goes on when number matches and enable active
// [RULE5] enable inactive: output held, no comparison made
// [RULE6] unconnected enable reads as active; a floating func_enable here reads inactive, calls never set the output
// [RULE7] reset and enable both active: reset wins, output cleared
// [RULE8] during reset an incoming call leaves output unchanged
// [RULE9] unconnected reset reads as inactive
// [RULE10] pattern holds up to 28 chars of digits, plus, minus, parens, asterisk
// [RULE11] asterisk at end or alone matches any digit sequence
// [RULE12] trailing asterisk needs at least one caller character there
// [RULE13] retentive option keeps output across supply loss
// [RULE14] remote-access calls from matching number also trigger output
// [RULE15] seven or eight data bits selectable
// [RULE16] parity none, odd or even
// [RULE17] one or two stop bits
// [RULE18] 9600 or 19200 bits per second
// [RULE19] restore defaults gives 8 bits, no parity, 1 stop, 9600
// [RULE20] after power-up wait 0..10 s before sending startup string
// [RULE21] four-digit sim pin; non-digit gives pin error
// [RULE22] pin cancel allowed without entering pin
// [RULE23] modem sends ring and quoted caller-id lines ended by cr lf
module cid_caller_match_block
    import cid_pkg::*;
#(
    parameter int SEC_CYCLES = CID_CLK_HZ // clock rate: sets the second count and the bit time
) (
    input wire logic clk, // 40 MHz clock
    input wire logic reset, // synchronous active-high reset
    input wire logic func_enable, // block enable input
    input wire logic func_reset, // block reset input, clears output
    input wire logic rxd_pin, // serial data from modem
    input wire logic [CID_PAT_LEN*8-1:0] pattern, // stored pattern, char 0 in low byte
    input wire logic [4:0] pattern_len, // pattern length in chars
    input wire logic [4:0] ring_count, // rings before detect
    input wire logic retentive, // retentive option select
    input wire logic retained_value, // value restored at power-up when retentive
    input wire logic data_bits_7, // 1: seven data bits
    input wire logic [1:0] parity_mode, // parity setting
    input wire logic stop_bits_2, // 1: two stop bits
    input wire logic baud_fast, // 1: 19200 bps
    input wire logic restore_defaults, // one-cycle pulse: default serial format
    input wire logic [3:0] delay_s, // startup delay seconds
    input wire logic [15:0] pin_digits, // four pin digit codes, 4 bits each
    input wire logic pin_enter, // pulse: submit pin
    input wire logic pin_cancel, // pulse: cancel pin
    output logic bit_out, // detector output
    output logic startup_send, // pulse: transmit startup string now
    output logic pin_error, // last pin entry rejected
    output logic pin_active, // pin set
    output logic [15:0] pin_value, // stored pin
    output logic [8:0] serial_frame_settings // {baud,stop2,parity,bits7,pad,...}
);
    // bit time follows the real clock rate; too few cycles per bit cannot find mid-bit
    localparam logic [15:0] DIV_SLOW = 16'(SEC_CYCLES / CID_BAUD_SLOW);
    localparam logic [15:0] DIV_FAST = 16'(SEC_CYCLES / CID_BAUD_FAST);
    initial begin
        if (SEC_CYCLES / CID_BAUD_FAST < 4 || SEC_CYCLES / CID_BAUD_SLOW > 32'h0000_ffff)
            $error("SEC_CYCLES cannot serve both bit rates");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // input synchroniser: 3 flops, change accepted when stages 2 and 3 agree
    logic [2:0] sync_reg, sync_next;
    logic rx_reg, rx_next;
    always_comb begin
        sync_next = {sync_reg[1:0], rxd_pin};
        rx_next = (sync_reg[2] == sync_reg[1]) ? sync_reg[2] : rx_reg;
    end
    always_ff @(posedge clk) begin
        sync_reg <= reset ? 3'h7 : sync_next;
        rx_reg <= reset ? 1'b1 : rx_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial format settings; reset and restore both land on the defaults
    logic fmt_bits7_reg, fmt_bits7_next, fmt_stop2_reg, fmt_stop2_next;
    logic fmt_fast_reg, fmt_fast_next;
    logic [1:0] fmt_par_reg, fmt_par_next;
    always_comb begin
        fmt_bits7_next = data_bits_7; // RULE15
        fmt_par_next = (parity_mode > CID_PAR_EVEN) ? CID_PAR_NONE : parity_mode; // RULE16
        fmt_stop2_next = stop_bits_2; // RULE17
        fmt_fast_next = baud_fast; // RULE18
        if (restore_defaults) begin
            fmt_bits7_next = 1'b0; // RULE19
            fmt_par_next = CID_PAR_NONE;
            fmt_stop2_next = 1'b0;
            fmt_fast_next = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        fmt_bits7_reg <= reset ? 1'b0 : fmt_bits7_next;
        fmt_par_reg <= reset ? CID_PAR_NONE : fmt_par_next;
        fmt_stop2_reg <= reset ? 1'b0 : fmt_stop2_next;
        fmt_fast_reg <= reset ? 1'b0 : fmt_fast_next;
        serial_frame_settings <= reset ? 9'h000 :
            {fmt_fast_next, fmt_stop2_next, fmt_par_next, fmt_bits7_next, 4'h0};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // uart receiver; stop bits are checked only as the first one, second is idle time
    cid_rx_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic ch_valid_reg, ch_valid_next;
    logic [7:0] ch_reg, ch_next;
    logic par_acc;
    logic [15:0] div;
    always_comb begin
        div = fmt_fast_reg ? DIV_FAST : DIV_SLOW; // RULE18
        st_next = st_reg;
        cnt_next = cnt_reg - 16'h0001;
        bit_next = bit_reg;
        sh_next = sh_reg;
        ch_valid_next = 1'b0;
        ch_next = ch_reg;
        par_acc = ^sh_reg ^ rx_reg;
        unique case (st_reg)
            CID_RX_IDLE: begin
                if (!rx_reg) begin
                    st_next = CID_RX_DATA;
                    cnt_next = div + (div >> 1); // sample mid first data bit
                    bit_next = 3'h0;
                    sh_next = 8'h00;
                end
            end
            CID_RX_DATA: begin
                if (cnt_reg == 16'h0000) begin
                    cnt_next = div - 16'h0001; // sample edge counts as part of the bit
                    sh_next = fmt_bits7_reg ? {1'b0, rx_reg, sh_reg[6:1]}
                                            : {rx_reg, sh_reg[7:1]}; // RULE15
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == (fmt_bits7_reg ? 3'h6 : 3'h7))
                        st_next = (fmt_par_reg == CID_PAR_NONE) ? CID_RX_STOP : CID_RX_PAR;
                end
            end
            CID_RX_PAR: begin
                if (cnt_reg == 16'h0000) begin
                    cnt_next = div - 16'h0001;
                    st_next = CID_RX_STOP;
                    // bad parity drops the char so noise cannot forge a number
                    if (fmt_par_reg == CID_PAR_ODD ? !par_acc : par_acc) // RULE16
                        sh_next = 8'h00;
                end
            end
            CID_RX_STOP: begin
                if (cnt_reg == 16'h0000) begin
                    st_next = CID_RX_IDLE; // RULE17
                    ch_valid_next = rx_reg && (sh_reg != 8'h00);
                    ch_next = sh_reg;
                end
            end
            default: st_next = CID_RX_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        st_reg <= reset ? CID_RX_IDLE : st_next;
        cnt_reg <= reset ? 16'h0000 : cnt_next;
        bit_reg <= reset ? 3'h0 : bit_next;
        sh_reg <= reset ? 8'h00 : sh_next;
        ch_valid_reg <= reset ? 1'b0 : ch_valid_next;
        ch_reg <= reset ? 8'h00 : ch_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line parser: ring lines counted, quoted number captured from caller-id line
    logic [4:0] rings_reg, rings_next;
    logic [4:0] lpos_reg, lpos_next;
    logic is_ring_reg, is_ring_next, is_clip_reg, is_clip_next;
    logic inq_reg, inq_next, qdone_reg, qdone_next;
    logic [CID_PAT_LEN*8-1:0] num_reg, num_next;
    logic [4:0] nlen_reg, nlen_next;
    logic call_reg, call_next;
    logic [4:0] ring_lim;
    always_comb begin
        ring_lim = (ring_count < 5'(CID_RING_MIN)) ? 5'(CID_RING_MIN) :
                   (ring_count > 5'(CID_RING_MAX)) ? 5'(CID_RING_MAX) : ring_count; // RULE2
        rings_next = rings_reg;
        lpos_next = lpos_reg;
        is_ring_next = is_ring_reg;
        is_clip_next = is_clip_reg;
        inq_next = inq_reg;
        qdone_next = qdone_reg;
        num_next = num_reg;
        nlen_next = nlen_reg;
        call_next = 1'b0;
        if (ch_valid_reg) begin
            if (ch_reg == CID_CH_LF) begin // RULE23
                if (is_ring_reg && rings_reg < 5'(CID_RING_MAX))
                    rings_next = rings_reg + 5'h01; // RULE1
                if (is_clip_reg && qdone_reg && rings_reg >= ring_lim) begin
                    call_next = 1'b1; // RULE1
                    rings_next = 5'h00;
                end
                lpos_next = 5'h00;
                is_ring_next = 1'b0;
                is_clip_next = 1'b0;
                inq_next = 1'b0;
            end else if (ch_reg != CID_CH_CR) begin
                if (lpos_reg == 5'h00) begin
                    is_ring_next = (ch_reg == CID_CH_R);
                    is_clip_next = (ch_reg == CID_CH_PLUS);
                    qdone_next = 1'b0;
                end
                if (lpos_reg == 5'h01 && is_clip_reg)
                    is_clip_next = (ch_reg == CID_CH_C);
                if (lpos_reg != 5'h1f)
                    lpos_next = lpos_reg + 5'h01;
                if (is_clip_reg && !qdone_reg && ch_reg == CID_CH_QUOTE) begin
                    if (inq_reg) qdone_next = 1'b1;
                    else begin
                        nlen_next = 5'h00;
                        num_next = '0;
                    end
                    inq_next = !inq_reg;
                end else if (inq_reg && nlen_reg < 5'(CID_PAT_LEN)) begin
                    num_next[nlen_reg*8 +: 8] = ch_reg;
                    nlen_next = nlen_reg + 5'h01;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        rings_reg <= reset ? 5'h00 : rings_next;
        lpos_reg <= reset ? 5'h00 : lpos_next;
        is_ring_reg <= reset ? 1'b0 : is_ring_next;
        is_clip_reg <= reset ? 1'b0 : is_clip_next;
        inq_reg <= reset ? 1'b0 : inq_next;
        qdone_reg <= reset ? 1'b0 : qdone_next;
        num_reg <= reset ? '0 : num_next;
        nlen_reg <= reset ? 5'h00 : nlen_next;
        call_reg <= reset ? 1'b0 : call_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pattern compare; any call, remote access included, is compared alike (RULE14)
    logic match;
    logic wild;
    logic [4:0] plen;
    always_comb begin
        plen = (pattern_len > 5'(CID_PAT_LEN)) ? 5'(CID_PAT_LEN) : pattern_len; // RULE10
        wild = (plen != 5'h00) && (pattern[(plen-5'h01)*8 +: 8] == CID_CH_STAR); // RULE11
        // trailing star needs at least one caller char in its place
        match = wild ? (nlen_reg >= plen) : (nlen_reg == plen); // RULE3 RULE12
        for (int i = 0; i < CID_PAT_LEN; i++) begin
            if (5'(i) < plen && !(wild && 5'(i) == plen - 5'h01))
                if (pattern[i*8 +: 8] != num_reg[i*8 +: 8]) match = 1'b0; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit output: func_reset first, then enable; ports default enable=1 reset=0 upstream
    logic boot_reg, boot_next;
    logic out_next;
    always_comb begin
        boot_next = 1'b0;
        out_next = bit_out;
        if (func_reset)
            out_next = 1'b0; // RULE7 RULE8 RULE9
        else if (boot_reg)
            out_next = retentive & retained_value; // RULE13
        else if (func_enable && call_reg && match)
            out_next = 1'b1; // RULE4 RULE6 RULE14
        // enable low: held, no compare used RULE5
    end
    always_ff @(posedge clk) begin
        boot_reg <= reset ? 1'b1 : boot_next;
        bit_out <= reset ? 1'b0 : out_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // startup delay before modem string, counted in seconds
    logic [31:0] tick_reg, tick_next;
    logic [3:0] sec_reg, sec_next;
    logic sent_reg, sent_next, send_next;
    logic [3:0] dly;
    always_comb begin
        dly = (delay_s > 4'(CID_DELAY_MAX_S)) ? 4'(CID_DELAY_MAX_S) : delay_s; // RULE20
        tick_next = tick_reg;
        sec_next = sec_reg;
        sent_next = sent_reg;
        send_next = 1'b0;
        if (!sent_reg) begin
            if (sec_reg >= dly) begin
                send_next = 1'b1; // RULE20
                sent_next = 1'b1;
            end else if (tick_reg == 32'(SEC_CYCLES - 1)) begin
                tick_next = 32'h0000_0000;
                sec_next = sec_reg + 4'h1;
            end else tick_next = tick_reg + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk) begin
        tick_reg <= reset ? 32'h0000_0000 : tick_next;
        sec_reg <= reset ? 4'h0 : sec_next;
        sent_reg <= reset ? 1'b0 : sent_next;
        startup_send <= reset ? 1'b0 : send_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sim pin entry and cancel
    logic pin_ok;
    logic perr_next, pact_next;
    logic [15:0] pval_next;
    always_comb begin
        pin_ok = 1'b1;
        for (int d = 0; d < 4; d++)
            if (pin_digits[d*4 +: 4] > 4'h9) pin_ok = 1'b0; // RULE21
        perr_next = pin_error;
        pact_next = pin_active;
        pval_next = pin_value;
        if (pin_cancel) begin
            pact_next = 1'b0; // RULE22
            pval_next = 16'h0000;
            perr_next = 1'b0;
        end else if (pin_enter) begin
            perr_next = !pin_ok; // RULE21
            if (pin_ok) begin
                pact_next = 1'b1;
                pval_next = pin_digits;
            end
        end
    end
    always_ff @(posedge clk) begin
        pin_error <= reset ? 1'b0 : perr_next;
        pin_active <= reset ? 1'b0 : pact_next;
        pin_value <= reset ? 16'h0000 : pval_next;
    end
endmodule : cid_caller_match_block

// File: verification/cid_caller_match_block_assertions.sv
// port-level checks for the caller detector
module cid_caller_match_block_assertions
    import cid_pkg::*;
#(
    parameter int SEC_CYCLES = CID_CLK_HZ // cycles per second
) (
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic func_enable, // enable input
    input wire logic func_reset, // clear input
    input wire logic retentive, // keep option
    input wire logic retained_value, // kept value
    input wire logic data_bits_7, // seven bits
    input wire logic [1:0] parity_mode, // parity
    input wire logic stop_bits_2, // two stops
    input wire logic baud_fast, // fast rate
    input wire logic restore_defaults, // defaults pulse
    input wire logic [3:0] delay_s, // startup delay
    input wire logic [15:0] pin_digits, // pin nibbles
    input wire logic pin_enter, // submit pin
    input wire logic pin_cancel, // cancel pin
    input wire logic bit_out, // detector output
    input wire logic startup_send, // startup pulse
    input wire logic pin_error, // pin rejected
    input wire logic pin_active, // pin set
    input wire logic [15:0] pin_value, // stored pin
    input wire logic [8:0] serial_frame_settings // frame settings
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    int cyc_reg;
    int cyc_next;
    int wait_cycles;
    logic pin_bad;
    // cycles since reset; saturates so a long run never wraps it
    always_comb begin
        wait_cycles = (delay_s > 4'ha ? 10 : int'(delay_s)) * SEC_CYCLES;
        cyc_next = (cyc_reg > wait_cycles + 16) ? cyc_reg : cyc_reg + 1;
        pin_bad = (pin_digits[3:0] > 4'h9) || (pin_digits[7:4] > 4'h9)
            || (pin_digits[11:8] > 4'h9) || (pin_digits[15:12] > 4'h9);
    end
    always_ff @(posedge clk) begin
        cyc_reg <= reset ? 0 : cyc_next;
    end
    ////////////////////////////////////////
    startup_time_a: assert property (startup_send |-> cyc_reg + 2 >= wait_cycles
        && cyc_reg <= wait_cycles + 8) else $error("startup string sent at wrong time");
    frame_follow_a: assert property (!restore_defaults && !$past(reset) |=>
        serial_frame_settings == {$past(baud_fast), $past(stop_bits_2),
        ($past(parity_mode) == 2'h3) ? 2'h0 : $past(parity_mode), $past(data_bits_7), 4'h0})
        else $error("frame settings do not follow inputs");
    frame_default_a: assert property (restore_defaults |=> serial_frame_settings == 9'h000)
        else $error("defaults not restored");
    pin_reject_a: assert property (pin_enter && pin_bad |=> pin_error)
        else $error("bad pin accepted");
    pin_accept_a: assert property (pin_enter && !pin_bad && !pin_cancel |=>
        !pin_error && pin_active && pin_value == $past(pin_digits)) else $error("pin refused");
    pin_cancel_a: assert property (pin_cancel && !pin_enter |=> !pin_active)
        else $error("pin not cancelled");
    clear_wins_a: assert property (func_reset |=> !bit_out)
        else $error("output not cleared");
    hold_disabled_a: assert property (!func_enable && !func_reset && !$past(reset)
        && !$past(reset, 2) |=> $stable(bit_out)) else $error("output moved while disabled");
    rise_cause_a: assert property ($rose(bit_out) && !$past(reset) && !$past(reset, 2)
        |-> $past(func_enable) && !$past(func_reset)) else $error("output rose without cause");
    keep_value_a: assert property ($fell(reset) && retentive && retained_value
        |-> ##[1:3] bit_out) else $error("kept value not restored");
    call_seen_c: cover property ($rose(bit_out));
    startup_seen_c: cover property (startup_send);
    pin_refused_c: cover property (pin_enter && pin_bad);
endmodule // cid_caller_match_block_assertions

// File: verification/cid_caller_match_block_test.sv
// self-checking bench for the caller detector
module cid_caller_match_block_test
    import cid_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SIM_HZ = 192_000; // ten cycles per bit at the fast rate
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic func_enable = 1'b1;
    logic func_reset = 1'b0;
    logic rxd_pin;
    logic [CID_PAT_LEN*8-1:0] pattern = '0;
    logic [4:0] pattern_len = 5'h0;
    logic [4:0] ring_count = 5'h1;
    logic retentive = 1'b0;
    logic retained_value = 1'b0;
    logic data_bits_7 = 1'b0;
    logic [1:0] parity_mode = 2'h0;
    logic stop_bits_2 = 1'b0;
    logic baud_fast = 1'b1;
    logic restore_defaults = 1'b0;
    logic [3:0] delay_s = 4'h0; // a whole second would outlast the run
    logic [15:0] pin_digits = 16'h0000;
    logic pin_enter = 1'b0;
    logic pin_cancel = 1'b0;
    logic bit_out, startup_send, pin_error, pin_active;
    logic [15:0] pin_value;
    logic [8:0] serial_frame_settings;
    logic [8:0] exp9;
    int mismatches = 0;
    int samples_checked = 0;
    int n;
    cid_caller_match_block #(.SEC_CYCLES(SIM_HZ)) dut (.clk(clk), .reset(reset),
        .func_enable(func_enable), .func_reset(func_reset), .rxd_pin(rxd_pin),
        .pattern(pattern), .pattern_len(pattern_len), .ring_count(ring_count),
        .retentive(retentive), .retained_value(retained_value), .data_bits_7(data_bits_7),
        .parity_mode(parity_mode), .stop_bits_2(stop_bits_2), .baud_fast(baud_fast),
        .restore_defaults(restore_defaults), .delay_s(delay_s), .pin_digits(pin_digits),
        .pin_enter(pin_enter), .pin_cancel(pin_cancel), .bit_out(bit_out),
        .startup_send(startup_send), .pin_error(pin_error), .pin_active(pin_active),
        .pin_value(pin_value), .serial_frame_settings(serial_frame_settings));
    cid_modem_model #(.SEC_CYCLES(SIM_HZ)) modem (.clk(clk), .bits7(data_bits_7), .par(parity_mode),
        .stop2(stop_bits_2), .fast(baud_fast), .rxd(rxd_pin));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////
    // bench inputs change 2 ns after an edge, outputs are read there too; the modem moves rxd_pin 1 ns after one
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic press(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic set_pattern(input string s);
        pattern = '0;
        foreach (s[i]) pattern[8*i +: 8] = s[i];
        pattern_len = 5'(s.len());
    endtask
    // a call is some ring lines and then the caller-id line with the number
    task automatic call(input int rings, input string num, input logic exp);
        repeat (rings) modem.send_line("RING");
        modem.send_line({"+CLIP: \"", num, "\""});
        step(4);
        check("bit_out", 16'(exp), 16'(bit_out));
    endtask
    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // the calls take some 20,000 cycles of serial time; 80,000 leaves headroom
    initial begin
        #2_000_000;
        mismatches++;
        summarize();
    end
    initial begin
        step(12);
        reset = 1'b0;
        check("bit_out", 16'h0000, 16'(bit_out));
        for (n = 0; n < 400 && startup_send !== 1'b1; n++) step(1);
        check("startup_send", 16'h0001, 16'(startup_send));
        for (int m = 0; m < 32; m++) begin
            {baud_fast, stop_bits_2, parity_mode, data_bits_7} = 5'(m);
            step(1);
            exp9 = {5'(m), 4'h0};
            if (m[2:1] == 2'h3) exp9[6:5] = 2'h0;
            check("frame", 16'(exp9), 16'(serial_frame_settings));
        end
        press(restore_defaults);
        check("frame", 16'h0000, 16'(serial_frame_settings));
        {baud_fast, stop_bits_2, parity_mode, data_bits_7} = 5'h10;
        pin_digits = 16'h1234;
        press(pin_enter);
        check("pin_value", 16'h1234, pin_value);
        check("pin_active", 16'h0001, 16'(pin_active));
        step(1);
        pin_digits = 16'h12a4;
        press(pin_enter);
        check("pin_error", 16'h0001, 16'(pin_error));
        press(pin_cancel);
        check("pin_active", 16'h0000, 16'(pin_active));
        ring_count = 5'h2;
        set_pattern("5");
        call(1, "5", 1'b0);
        call(2, "5", 1'b1);
        func_reset = 1'b1;
        step(1);
        check("bit_out", 16'h0000, 16'(bit_out));
        ring_count = 5'h1;
        call(1, "5", 1'b0);
        func_reset = 1'b0;
        func_enable = 1'b0;
        call(1, "5", 1'b0);
        func_enable = 1'b1;
        call(1, "5", 1'b1);
        press(func_reset);
        set_pattern("56");
        call(1, "567", 1'b0);
        {data_bits_7, parity_mode, stop_bits_2} = {1'b1, CID_PAR_ODD, 1'b1};
        call(1, "56", 1'b1);
        {data_bits_7, parity_mode, stop_bits_2} = {1'b0, CID_PAR_EVEN, 1'b0};
        press(func_reset);
        set_pattern("5*");
        call(1, "5", 1'b0);
        call(1, "57", 1'b1);
        press(func_reset);
        set_pattern("+*");
        call(1, "+4", 1'b1);
        retentive = 1'b1;
        retained_value = 1'b1;
        reset = 1'b1;
        step(12);
        reset = 1'b0;
        step(3);
        check("bit_out", 16'h0001, 16'(bit_out));
        summarize();
    end
endmodule // cid_caller_match_block_test
bind cid_caller_match_block cid_caller_match_block_assertions #(.SEC_CYCLES(SEC_CYCLES)) chk (
    .clk(clk), .reset(reset), .func_enable(func_enable), .func_reset(func_reset),
    .retentive(retentive), .retained_value(retained_value), .data_bits_7(data_bits_7),
    .parity_mode(parity_mode), .stop_bits_2(stop_bits_2), .baud_fast(baud_fast),
    .restore_defaults(restore_defaults), .delay_s(delay_s), .pin_digits(pin_digits),
    .pin_enter(pin_enter), .pin_cancel(pin_cancel), .bit_out(bit_out),
    .startup_send(startup_send), .pin_error(pin_error), .pin_active(pin_active),
    .pin_value(pin_value), .serial_frame_settings(serial_frame_settings));

// File: verification/cid_modem_model.sv
// behavioural modem sending notification lines to the controller
module cid_modem_model
    import cid_pkg::*;
#(
    parameter int SEC_CYCLES = CID_CLK_HZ // controller clock rate
) (
    input wire logic clk, // controller clock paces the bits
    input wire logic bits7, // seven data bits
    input wire logic [1:0] par, // parity setting
    input wire logic stop2, // two stop bits
    input wire logic fast, // 19200 bps
    output logic rxd // serial line, idle high
);
    timeunit 1ns;
    timeprecision 100ps;
    initial rxd = 1'b1;
    ////////////////////////////////////////
    // one bit time, changed just after an edge so the receiver never races it
    task automatic bit_time(input logic v);
        rxd = v;
        repeat (fast ? SEC_CYCLES / CID_BAUD_FAST : SEC_CYCLES / CID_BAUD_SLOW) @(posedge clk);
        #1;
    endtask
    // one character, lsb first; parity covers only the bits really sent
    task automatic send_char(input logic [7:0] c);
        logic [7:0] d;
        d = bits7 ? {1'b0, c[6:0]} : c;
        bit_time(1'b0);
        for (int i = 0; i < (bits7 ? 7 : 8); i++) bit_time(d[i]);
        if (par == CID_PAR_ODD || par == CID_PAR_EVEN) bit_time(^d ^ (par == CID_PAR_ODD));
        bit_time(1'b1);
        if (stop2) bit_time(1'b1);
    endtask
    // every notification is a line of its own
    task automatic send_line(input string s);
        foreach (s[i]) send_char(s[i]);
        send_char(CID_CH_CR);
        send_char(CID_CH_LF);
    endtask
endmodule // cid_modem_model
